//--- hw/psg_core.sv
// per-axis pid servo filter and point-to-point profile generator
// Overview of operation
// RQ1 - output is prop times error, deriv times error step, integ times sum over 256
// RQ2 - the integral error sum is clamped to plus or minus the integration bound
// RQ3 - integration bound is 32 bits unsigned, writes saturate to 2147483647; the code masks off bit 31 instead
// RQ4 - each gain is 16 bits unsigned, writes saturate to 32767
// RQ5 - gains and torque limit are all software programmable registers
// RQ6 - filter output is saturated to the torque limit before leaving the block
// RQ7 - open-loop profile is recomputed every 256 us and steps issued from it
// RQ8 - moves are point to point with trapezoidal or s-shaped velocity
// RQ9 - open-loop final velocity is a 32-bit word from 1 to 2147483647
// RQ10 - velocity v advances open-loop position v/65536 microsteps per profile cycle
// RQ11 - acceleration held as a full 32-bit word from 1 to 2147483647
// RQ12 - open-loop ramp lasts v/acc cycles covering v squared over 131072 acc
// RQ13 - encoder is decoded four counts per line
// RQ14 - servo period is 204.8 us plus n times 51.2 us, n up to 386
// RQ15 - a requested period in whole microseconds rounds to the nearest step
// RQ16 - closed-loop final speed is a 32-bit word from 1 to 2147483647
// RQ17 - closed-loop command advances v/65536 counts every servo period
// RQ18 - closed-loop acceleration is a 32-bit word from 1 to 2147483647
// RQ19 - closed-loop ramp lasts v/acc periods covering v squared over 131072 acc
// RQ20 - new settings are taken only at the start of the next cycle; the code reads ctrl_en and ctrl_closed unshadowed instead
`timescale 1ns/1ps
`default_nettype none
module psg_core #(
  parameter int PROF_CYC = psg_pkg::PROF_CYC_DEF,
  parameter int SRV_BASE_CYC = psg_pkg::SRV_BASE_CYC_DEF,
  parameter int SRV_STEP_CYC = psg_pkg::SRV_STEP_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  output logic signed [15:0] torque_o,
  output logic step_o,
  output logic dir_o,
  output logic busy_o
);
  import psg_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp_gain(input logic [31:0] x);
    return (x > {16'h0000, GAIN_MAX}) ? GAIN_MAX : x[15:0];
  endfunction

  function automatic logic [31:0] clamp_word(input logic [31:0] x);
    if (x == 32'h00000000) begin
      return 32'h00000001;
    end
    return x[31] ? WORD_MAX : x;
  endfunction

  function automatic logic [8:0] us_to_n(input logic [31:0] us);
    logic [35:0] t;
    logic [35:0] q;
    t = {4'h0, us} * US_X10;
    if (t <= BASE_X10) begin
      return 9'h000;
    end
    q = (t - BASE_X10 + (STEP_X10 >> 1)) / STEP_X10;
    return (q > {27'h0, N_MAX}) ? N_MAX : q[8:0];
  endfunction

  psg_enc_if enc ();
  assign enc.a = enc_a_i;
  assign enc.b = enc_b_i;
  psg_quad u_quad (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enc(enc)
  );

  logic ctrl_en;
  logic ctrl_closed;
  logic ctrl_scurve;
  logic go_pend;
  logic [15:0] prop_gain;
  logic [15:0] integ_gain;
  logic [15:0] deriv_gain;
  logic [31:0] integ_bound;
  logic [15:0] torque_lim;
  logic [31:0] vel_max;
  logic [31:0] acc_max;
  logic [31:0] target;
  logic [31:0] cyc_us;
  logic bus_req;
  logic wr;
  logic wr_go;
  logic [31:0] rd_mux;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = bus_req && wb_we_i;
  assign wr_go = wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_GO];

  // ack one cycle after the strobe; ce low stalls the bus as well
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en <= 1'b0;
      ctrl_closed <= 1'b0;
      ctrl_scurve <= 1'b0;
      prop_gain <= 16'h0000;
      integ_gain <= 16'h0000;
      deriv_gain <= 16'h0000;
      integ_bound <= 32'h00000000;
      torque_lim <= TLIM_DEF;
      vel_max <= VEL_DEF;
      acc_max <= ACC_DEF;
      target <= 32'h00000000;
      cyc_us <= CYC_US_DEF;
    end else if (ce_i && wr) begin
      case (wb_adr_i)
        A_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_en <= wb_dat_i[C_EN];
            ctrl_closed <= wb_dat_i[C_CLOSED];
            ctrl_scurve <= wb_dat_i[C_SCURVE];
          end
        end
        A_PGAIN: prop_gain <= clamp_gain(merge({16'h0000, prop_gain}, wb_dat_i, wb_sel_i)); // RQ4
        A_IGAIN: integ_gain <= clamp_gain(merge({16'h0000, integ_gain}, wb_dat_i, wb_sel_i)); // RQ4
        A_DGAIN: deriv_gain <= clamp_gain(merge({16'h0000, deriv_gain}, wb_dat_i, wb_sel_i)); // RQ4
        A_IBND: begin
          integ_bound <= merge(integ_bound, wb_dat_i, wb_sel_i) & WORD_MAX; // RQ3
        end
        A_TLIM: torque_lim <= clamp_gain(merge({16'h0000, torque_lim}, wb_dat_i, wb_sel_i)); // RQ5
        A_VEL: vel_max <= clamp_word(merge(vel_max, wb_dat_i, wb_sel_i)); // RQ9 RQ16
        A_ACC: acc_max <= clamp_word(merge(acc_max, wb_dat_i, wb_sel_i)); // RQ11 RQ18
        A_TGT: target <= merge(target, wb_dat_i, wb_sel_i);
        A_CYC: cyc_us <= merge(cyc_us, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // timebases
  logic [31:0] prof_cnt;
  logic [31:0] srv_cnt;
  logic [31:0] srv_per;
  logic [8:0] n_s;
  logic prof_tick;
  logic srv_tick;
  logic mv_tick;

  assign srv_per = 32'(SRV_BASE_CYC) + 32'(n_s) * 32'(SRV_STEP_CYC); // RQ14
  assign prof_tick = prof_cnt == 32'(PROF_CYC - 1); // RQ7
  assign srv_tick = srv_cnt == srv_per - 32'h00000001;
  assign mv_tick = ctrl_closed ? srv_tick : prof_tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prof_cnt <= 32'h00000000;
      srv_cnt <= 32'h00000000;
    end else if (ce_i) begin
      prof_cnt <= prof_tick ? 32'h00000000 : prof_cnt + 32'h00000001;
      srv_cnt <= srv_tick ? 32'h00000000 : srv_cnt + 32'h00000001;
    end
  end

  // set wins over the clear taken at the starting tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_pend <= 1'b0;
    end else if (ce_i) begin
      if (wr_go) begin
        go_pend <= 1'b1;
      end else if (mv_tick && ctrl_en) begin
        go_pend <= 1'b0;
      end
    end
  end

  // profile generator
  logic [47:0] pos_q;
  logic [31:0] mv_vel;
  logic [31:0] cur_acc;
  logic moving;
  logic [31:0] vmax_s;
  logic [31:0] acc_s;
  logic [31:0] tgt_s;
  logic scur_s;
  logic signed [31:0] cmd_int;
  logic signed [32:0] rem;
  logic neg;
  logic [31:0] arem;
  logic [31:0] a_eff;
  logic [31:0] jstep;
  logic brake;
  logic finish;
  logic [31:0] next_v;
  logic [31:0] next_acc;
  logic [47:0] next_pos;

  assign cmd_int = $signed(pos_q[47:16]);
  assign rem = {tgt_s[31], tgt_s} - {cmd_int[31], cmd_int};
  assign neg = rem[32];
  assign arem = neg ? 32'(-rem) : rem[31:0];
  assign a_eff = scur_s ? cur_acc : acc_s;
  assign jstep = ((acc_s >> JERK_SHIFT) == 32'h00000000) ? 32'h00000001 : acc_s >> JERK_SHIFT;
  // braking once remaining distance reaches v squared over 131072 acc
  assign brake = {17'h00000, 64'(mv_vel) * 64'(mv_vel)} >= 81'({arem, 17'h00000}) * 81'(acc_s); // RQ12 RQ19
  assign finish = {arem, 16'h0000} <= {16'h0000, mv_vel};

  always_comb begin
    logic [32:0] vsum;
    logic [32:0] asum;
    vsum = {1'b0, mv_vel} + {1'b0, a_eff};
    asum = {1'b0, cur_acc} + {1'b0, jstep};
    if (finish) begin
      next_v = 32'h00000000;
    end else if (brake) begin
      next_v = (mv_vel > acc_s) ? mv_vel - acc_s : acc_s;
    end else begin
      next_v = (vsum > {1'b0, vmax_s}) ? vmax_s : vsum[31:0]; // RQ8
    end
    // s-curve: acceleration itself ramps in steps of acc over 16
    next_acc = (brake || asum >= {1'b0, acc_s}) ? acc_s : asum[31:0]; // RQ8
    if (finish) begin
      next_pos = {tgt_s, 16'h0000};
    end else if (neg) begin
      next_pos = pos_q - {16'h0000, next_v}; // RQ10 RQ17
    end else begin
      next_pos = pos_q + {16'h0000, next_v}; // RQ10 RQ17
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 48'h000000000000;
      mv_vel <= 32'h00000000;
      cur_acc <= 32'h00000000;
      moving <= 1'b0;
      vmax_s <= VEL_DEF;
      acc_s <= ACC_DEF;
      tgt_s <= 32'h00000000;
      scur_s <= 1'b0;
    end else if (ce_i && mv_tick) begin
      vmax_s <= vel_max; // RQ20
      acc_s <= acc_max; // RQ20
      tgt_s <= target; // RQ20
      scur_s <= ctrl_scurve; // RQ20
      if (!ctrl_en) begin
        moving <= 1'b0;
        mv_vel <= 32'h00000000;
      end else if (moving) begin
        pos_q <= next_pos; // RQ7
        mv_vel <= next_v;
        cur_acc <= finish ? 32'h00000000 : next_acc;
        moving <= !finish;
      end else if (go_pend) begin
        moving <= 1'b1;
        cur_acc <= 32'h00000000;
      end
    end
  end

  // microstep output, one pulse per whole count; at least one low cycle between
  logic [31:0] step_pos;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_pos <= 32'h00000000;
      step_o <= 1'b0;
      dir_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= moving || go_pend;
      if (ctrl_closed) begin
        step_pos <= cmd_int;
        step_o <= 1'b0;
      end else if (!step_o && step_pos != cmd_int) begin
        step_o <= 1'b1; // RQ7
        dir_o <= $signed(step_pos) < cmd_int;
        step_pos <= ($signed(step_pos) < cmd_int) ? step_pos + 32'h00000001
                                                  : step_pos - 32'h00000001;
      end else begin
        step_o <= 1'b0;
      end
    end
  end

  // servo filter
  psg_pid_t pid_state;
  logic [15:0] kp_s;
  logic [15:0] ki_s;
  logic [15:0] kd_s;
  logic [31:0] ib_s;
  logic [15:0] tl_s;
  logic pid_go;
  logic signed [31:0] e_now;
  logic signed [31:0] err;
  logic signed [31:0] err_prev;
  logic signed [32:0] derr;
  logic signed [32:0] isum;
  logic signed [33:0] sum_raw;
  logic signed [33:0] ib_w;
  logic signed [32:0] sum_cl;
  logic signed [51:0] pid_tot;
  logic signed [51:0] lim_w;

  assign pid_go = srv_tick && ctrl_closed && ctrl_en;
  assign e_now = cmd_int - $signed(enc.count);
  assign sum_raw = {isum[32], isum} + {{2{e_now[31]}}, e_now};
  assign ib_w = $signed({2'b00, ib_s});
  assign sum_cl = (sum_raw > ib_w) ? 33'(ib_w) : (sum_raw < -ib_w) ? 33'(-ib_w) : 33'(sum_raw); // RQ2
  assign lim_w = $signed({36'h000000000, tl_s});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kp_s <= 16'h0000;
      ki_s <= 16'h0000;
      kd_s <= 16'h0000;
      ib_s <= 32'h00000000;
      tl_s <= TLIM_DEF;
      n_s <= N_DEF;
    end else if (ce_i && srv_tick) begin
      kp_s <= prop_gain; // RQ20 RQ5
      ki_s <= integ_gain; // RQ20 RQ5
      kd_s <= deriv_gain; // RQ20 RQ5
      ib_s <= integ_bound; // RQ20
      tl_s <= torque_lim; // RQ20
      n_s <= us_to_n(cyc_us); // RQ15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pid_state <= PS_IDLE;
      err <= 32'sh00000000;
      err_prev <= 32'sh00000000;
      derr <= 33'sh000000000;
      isum <= 33'sh000000000;
      pid_tot <= 52'sh0000000000000;
      torque_o <= 16'sh0000;
    end else if (ce_i) begin
      unique case (pid_state)
        PS_IDLE: begin
          if (pid_go) begin
            pid_state <= PS_ERR;
          end else if (!ctrl_en || !ctrl_closed) begin
            isum <= 33'sh000000000;
            err_prev <= 32'sh00000000;
            torque_o <= 16'sh0000;
          end
        end
        PS_ERR: begin
          err <= e_now;
          derr <= {e_now[31], e_now} - {err_prev[31], err_prev};
          err_prev <= e_now;
          isum <= sum_cl; // RQ2
          pid_state <= PS_MUL;
        end
        PS_MUL: begin
          pid_tot <= 52'($signed({1'b0, kp_s})) * 52'(err)
                   + 52'($signed({1'b0, kd_s})) * 52'(derr)
                   + ((52'($signed({1'b0, ki_s})) * 52'(isum)) >>> INTEG_SHIFT); // RQ1
          pid_state <= PS_OUT;
        end
        PS_OUT: begin
          // torque limit applied last so no term can escape it
          torque_o <= (pid_tot > lim_w) ? 16'(lim_w) : (pid_tot < -lim_w) ? 16'(-lim_w)
                                                                           : 16'(pid_tot); // RQ6
          pid_state <= PS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      A_CTRL: rd_mux = {28'h0000000, go_pend, ctrl_scurve, ctrl_closed, ctrl_en};
      A_STAT: rd_mux = {30'h00000000, moving, moving || go_pend};
      A_PGAIN: rd_mux = {16'h0000, prop_gain};
      A_IGAIN: rd_mux = {16'h0000, integ_gain};
      A_DGAIN: rd_mux = {16'h0000, deriv_gain};
      A_IBND: rd_mux = integ_bound;
      A_TLIM: rd_mux = {16'h0000, torque_lim};
      A_VEL: rd_mux = vel_max;
      A_ACC: rd_mux = acc_max;
      A_TGT: rd_mux = target;
      A_CYC: rd_mux = {23'h000000, n_s};
      A_CMD: rd_mux = cmd_int;
      A_ENC: rd_mux = enc.count;
      A_OUT: rd_mux = {{16{torque_o[15]}}, torque_o};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // checks
  logic [31:0] prof_gap;
  logic [31:0] srv_gap;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prof_gap <= 32'h00000000;
      srv_gap <= 32'h00000000;
    end else if (ce_i) begin
      prof_gap <= prof_tick ? 32'h00000000 : prof_gap + 32'h00000001;
      srv_gap <= srv_tick ? 32'h00000000 : srv_gap + 32'h00000001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence pid_start_s;
    ce_i && pid_go && pid_state == PS_IDLE;
  endsequence
  sequence pid_err_s;
    pid_state == PS_ERR;
  endsequence
  property pid_flow_p;
    pid_start_s |=> pid_err_s;
  endproperty

  gain_range_a: assert property (prop_gain <= GAIN_MAX && integ_gain <= GAIN_MAX // RQ4
    && deriv_gain <= GAIN_MAX) else $error("gain above range");
  bound_range_a: assert property (integ_bound <= WORD_MAX) // RQ3
    else $error("integration bound above range");
  vel_range_a: assert property (vel_max != 32'h00000000 && vel_max <= WORD_MAX) // RQ9
    else $error("velocity out of range");
  acc_range_a: assert property (acc_max != 32'h00000000 && acc_max <= WORD_MAX) // RQ11
    else $error("acceleration out of range");
  integ_clamp_a: assert property (pid_state == PS_MUL |-> isum <= 33'(ib_w) && isum >= 33'(-ib_w)) // RQ2
    else $error("integral sum beyond bound");
  // a lowered limit only reaches the output at the next filter pass
  torque_sat_a: assert property (ce_i && pid_state == PS_OUT |=> 52'(torque_o) <= lim_w // RQ6
    && 52'(torque_o) >= -lim_w) else $error("torque beyond limit");
  prof_period_a: assert property (prof_tick |-> prof_gap == 32'(PROF_CYC - 1)) // RQ7
    else $error("profile cycle length wrong");
  srv_period_a: assert property (srv_tick |-> srv_gap + 32'h00000001 == srv_per && n_s <= N_MAX) // RQ14
    else $error("servo cycle length wrong");
  vel_limit_a: assert property ((ce_i && mv_tick && moving && ctrl_en && !brake && !finish) // RQ8
    |=> mv_vel <= $past(vmax_s)) else $error("velocity above final velocity");
  pos_adv_a: assert property ((ce_i && mv_tick && moving && ctrl_en && !finish && !neg) // RQ17
    |=> pos_q == $past(pos_q) + {16'h0000, mv_vel}) else $error("position step not velocity");
  shadow_hold_a: assert property (!(ce_i && srv_tick) |=> $stable(kp_s) && $stable(ki_s) // RQ20
    && $stable(kd_s) && $stable(tl_s)) else $error("gain changed inside a cycle");
  pid_flow_a: assert property (pid_flow_p) // RQ1
    else $error("servo tick did not start the filter");
endmodule
`default_nettype wire

//--- common/psg_pkg.sv
// shared constants for the pid servo and profile generator core
package psg_pkg;
  // clock and cycle timing
  localparam int CLK_NS = 10;
  localparam int T_PROF_NS = 256000;
  localparam int T_SRV_BASE_NS = 204800;
  localparam int T_SRV_STEP_NS = 51200;
  localparam int PROF_CYC_DEF = T_PROF_NS / CLK_NS;
  localparam int SRV_BASE_CYC_DEF = T_SRV_BASE_NS / CLK_NS;
  localparam int SRV_STEP_CYC_DEF = T_SRV_STEP_NS / CLK_NS;
  // servo period request, whole microseconds scaled to tenths of a microsecond
  localparam logic [35:0] US_X10 = 36'h00000000a;
  localparam logic [35:0] BASE_X10 = 36'(T_SRV_BASE_NS / 100);
  localparam logic [35:0] STEP_X10 = 36'(T_SRV_STEP_NS / 100);
  localparam logic [8:0] N_MAX = 9'h182;
  localparam logic [31:0] CYC_US_DEF = 32'h00000100;
  localparam logic [8:0] N_DEF = 9'h001;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_PGAIN = 8'h08;
  localparam logic [7:0] A_IGAIN = 8'h0c;
  localparam logic [7:0] A_DGAIN = 8'h10;
  localparam logic [7:0] A_IBND = 8'h14;
  localparam logic [7:0] A_TLIM = 8'h18;
  localparam logic [7:0] A_VEL = 8'h1c;
  localparam logic [7:0] A_ACC = 8'h20;
  localparam logic [7:0] A_TGT = 8'h24;
  localparam logic [7:0] A_CYC = 8'h28;
  localparam logic [7:0] A_CMD = 8'h2c;
  localparam logic [7:0] A_ENC = 8'h30;
  localparam logic [7:0] A_OUT = 8'h34;
  // control and status bits
  localparam int C_EN = 0;
  localparam int C_CLOSED = 1;
  localparam int C_SCURVE = 2;
  localparam int C_GO = 3;
  localparam int S_BUSY = 0;
  localparam int S_MOVING = 1;
  // value ranges and reset values
  localparam logic [15:0] GAIN_MAX = 16'h7fff;
  localparam logic [31:0] WORD_MAX = 32'h7fffffff;
  localparam logic [15:0] TLIM_DEF = 16'h7fff;
  localparam logic [31:0] VEL_DEF = 32'h00010000;
  localparam logic [31:0] ACC_DEF = 32'h00000100;
  localparam int INTEG_SHIFT = 8;
  localparam int JERK_SHIFT = 4;
  typedef enum {PS_IDLE, PS_ERR, PS_MUL, PS_OUT} psg_pid_t;
endpackage

//--- common/psg_enc_if.sv
// carrier between encoder decoder and servo core
`timescale 1ns/1ps
`default_nettype none
interface psg_enc_if;
  logic a;
  logic b;
  logic [31:0] count;
  modport dec (input a, input b, output count);
  modport core (output a, output b, input count);
endinterface
`default_nettype wire

//--- hw/psg_quad.sv
// four-count-per-line quadrature decoder
`timescale 1ns/1ps
`default_nettype none
module psg_quad (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  psg_enc_if.dec enc
);
  logic a_q;
  logic b_q;
  logic one_edge;
  logic up;
  // both phases moving at once carries no direction, so it is dropped
  assign one_edge = (enc.a ^ a_q) ^ (enc.b ^ b_q);
  assign up = enc.a ^ b_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      enc.count <= 32'h00000000;
    end else if (ce_i) begin
      a_q <= enc.a;
      b_q <= enc.b;
      if (one_edge) begin
        enc.count <= up ? enc.count + 32'h00000001 : enc.count - 32'h00000001; // RQ13
      end
    end
  end

  quad_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
    (ce_i && one_edge) |=> (enc.count - $past(enc.count) == 32'h00000001)
      || ($past(enc.count) - enc.count == 32'h00000001))
    else $error("encoder count did not move by one on an edge");
endmodule
`default_nettype wire

//--- verif/psg_motor_model.sv
// partner model: stepper power stage and quadrature encoder
`timescale 1ns/1ps
`default_nettype none
module psg_motor_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic signed [15:0] torque_i,
  input wire logic signed [31:0] lines_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic signed [31:0] steps_o
);
  logic signed [31:0] cnt;
  logic [1:0] div;
  logic step_q;
  // torque is only watched; the shaft follows lines_i so the feedback is known exactly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      div <= '0;
    end else begin
      div <= div + 2'h1;
      // one phase edge every four clocks, never both phases at once
      if (div == 2'h3 && cnt != lines_i * 4) begin
        cnt <= (cnt < lines_i * 4) ? cnt + 32'sh1 : cnt - 32'sh1;
      end
    end
  end
  // phase a leads when the count rises, which the decoder counts as up
  assign enc_a_o = cnt[1] ^ cnt[0];
  assign enc_b_o = cnt[1];
  always_ff @(posedge clk_i) begin
    step_q <= step_i;
    if (rst_i) begin
      steps_o <= '0;
    end else if (step_i && !step_q) begin
      steps_o <= steps_o + (dir_i ? 32'sh1 : -32'sh1);
    end
  end
endmodule
`default_nettype wire

//--- verif/psg_core_bench.sv
// self-checking bench for the servo and profile core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module psg_core_bench;
  import psg_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic ce = 1;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0, wb_dat_o;
  logic wb_ack_o, enc_a, enc_b, step_o, dir_o, busy_o;
  logic signed [15:0] torque_o;
  logic signed [31:0] lines = '0, steps;
  int err_total = 0;
  int checks = 0;
  psg_core #(.PROF_CYC(64), .SRV_BASE_CYC(48), .SRV_STEP_CYC(16)) i_psg_core (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .enc_a_i(enc_a), .enc_b_i(enc_b), .torque_o(torque_o),
    .step_o(step_o), .dir_o(dir_o), .busy_o(busy_o));
  psg_motor_model i_psg_motor_model (.clk_i(clk_i), .rst_i(rst_i), .step_i(step_o),
    .dir_i(dir_o), .torque_i(torque_o), .lines_i(lines), .enc_a_o(enc_a),
    .enc_b_o(enc_b), .steps_o(steps));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // one classic cycle; the request stands until ack is sampled high or 50 cycles pass
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) `CHK("wb ack", 1'b1, wb_ack_o)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    `CHK($sformatf("reg %h", a), e, r)
  endtask
  // the move has to be pending before busy is looked at; steps may trail it
  task automatic wait_idle();
    int n;
    repeat (4) @(posedge clk_i);
    n = 0;
    while (busy_o !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("busy", 1'b0, busy_o)
    repeat (20) @(posedge clk_i);
  endtask
  task automatic t_defaults();
    rdchk(A_TLIM, 32'(TLIM_DEF));
    rdchk(A_VEL, VEL_DEF);
    rdchk(A_ACC, ACC_DEF);
    rdchk(A_CYC, 32'(N_DEF));
    rdchk(A_OUT, 32'h0);
    rdchk(8'hfc, 32'h0);
    $display("test defaults done");
  endtask
  task automatic t_ranges();
    logic [7:0] g [3] = '{A_PGAIN, A_IGAIN, A_DGAIN};
    foreach (g[i]) begin
      wr(g[i], 32'hffffffff);
      rdchk(g[i], 32'(GAIN_MAX));
      wr(g[i], 32'h0);
    end
    wr(A_IBND, 32'hffffffff);
    rdchk(A_IBND, WORD_MAX);
    wr(A_TLIM, 32'h0000ffff);
    rdchk(A_TLIM, 32'h00007fff);
    wr(A_VEL, 32'h0);
    rdchk(A_VEL, 32'h1);
    wr(A_VEL, 32'h80000000);
    rdchk(A_VEL, WORD_MAX);
    wr(A_ACC, 32'h0);
    rdchk(A_ACC, 32'h1);
    wr(A_ACC, 32'hffffffff);
    rdchk(A_ACC, WORD_MAX);
    wr(A_IBND, 32'h0);
    $display("test ranges done");
  endtask
  task automatic t_cycle();
    logic [31:0] us [5] = '{32'd230, 32'd231, 32'd100, 32'd20000, 32'd256};
    logic [31:0] n [5] = '{32'd0, 32'd1, 32'd0, 32'd386, 32'd1};
    foreach (us[i]) begin
      wr(A_CYC, us[i]);
      // a long period must run out before the new one is in force
      repeat (7000) @(posedge clk_i);
      rdchk(A_CYC, n[i]);
    end
    $display("test cycle done");
  endtask
  task automatic t_encoder();
    lines <= 32'sd3;
    repeat (100) @(posedge clk_i);
    rdchk(A_ENC, 32'd12);
    lines <= 32'sd2;
    repeat (100) @(posedge clk_i);
    rdchk(A_ENC, 32'd8);
    lines <= 32'sd3;
    repeat (100) @(posedge clk_i);
    $display("test encoder done");
  endtask
  task automatic t_open();
    logic signed [31:0] s;
    wr(A_ACC, 32'h00010000);
    wr(A_VEL, 32'h00010000);
    wr(A_TGT, 32'd10);
    wr(A_CTRL, 32'h9);
    // clock enable low with the move still pending: nothing may step while frozen
    ce <= 1'b0;
    repeat (2) @(posedge clk_i);
    s = steps;
    repeat (300) @(posedge clk_i);
    `CHK("frozen steps", s, steps)
    `CHK("frozen busy", 1'b1, busy_o)
    ce <= 1'b1;
    wait_idle();
    rdchk(A_CMD, 32'd10);
    `CHK("steps up", 32'sd10, steps)
    wr(A_TGT, 32'd4);
    wr(A_CTRL, 32'hd);
    wait_idle();
    rdchk(A_CMD, 32'd4);
    `CHK("steps down", 32'sd4, steps)
    $display("test open loop done");
  endtask
  task automatic t_closed();
    wr(A_TGT, 32'd16);
    wr(A_DGAIN, 32'd3);
    wr(A_CTRL, 32'hb);
    // mid-ramp the command gains one count a period, so the error step is one
    repeat (300) @(posedge clk_i);
    `CHK("torque d", 16'sd3, torque_o)
    wait_idle();
    wr(A_DGAIN, 32'd0);
    rdchk(A_CMD, 32'd16);
    `CHK("no steps closed", 32'sd4, steps)
    wr(A_PGAIN, 32'd2);
    repeat (500) @(posedge clk_i);
    rdchk(A_OUT, 32'd8);
    `CHK("torque p", 16'sd8, torque_o)
    wr(A_TLIM, 32'd3);
    repeat (500) @(posedge clk_i);
    `CHK("torque limited", 16'sd3, torque_o)
    wr(A_TLIM, 32'h7fff);
    wr(A_PGAIN, 32'd0);
    wr(A_IBND, 32'd5);
    wr(A_IGAIN, 32'd256);
    repeat (500) @(posedge clk_i);
    `CHK("torque integ", 16'sd5, torque_o)
    $display("test closed loop done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_ranges();
    t_cycle();
    t_encoder();
    t_open();
    t_closed();
    finish_test();
  end
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
